// >>> design/pmrc_pkg.sv
// How it works
// - idle bit write halts cpu, enters idle
// - idle keeps state, peripherals and clocks run
// - enabled interrupt ends idle, cpu resumes
// - idle wake resumes after setting instruction
// - reset ending idle restarts at vector
// - watchdog keeps counting in idle
// - stop bit write enters stop mode
// - stop halts cpu, oscillator, peripherals
// - only a reset ends stop mode
// - enabled missing clock detector resets stop
// - mode bits read zero, zero writes ignored
// - reset halts, reloads registers, disables peripherals
// - reset never touches data memory
// - reset forces port latches all ones
// - reset exit: pc cleared, slow oscillator
// - reset exit: watchdog on, longest interval
// - seven reset sources enter reset
// - supply monitor holds reset, 100 ms
// - power-on sets flag, others clear it
// - pin release holds reset 12 cycles
package pmrc_pkg;

    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned POR_TIMEOUT_MS   = 100;
    localparam int unsigned POR_TIMEOUT_CYC  = POR_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned PIN_HOLD_CYC     = 12;
    localparam int unsigned WDOG_CMD_WIN_CYC = 4;

    // register indices; byte address is four times the index
    localparam logic [7:0] PMC_IDX           = 8'h87;
    localparam logic [7:0] RCAUSE_IDX        = 8'hef;
    localparam logic [7:0] WDOG_IDX          = 8'hff;

    localparam logic [7:0] PMC_RESET         = 8'h00;
    localparam int unsigned PMC_IDLE_BIT     = 0;
    localparam int unsigned PMC_STOP_BIT     = 1;

    localparam int unsigned RC_PIN_BIT       = 0;
    localparam int unsigned RC_POR_BIT       = 1;
    localparam int unsigned RC_CLKMISS_BIT   = 2;
    localparam int unsigned RC_WDOG_BIT      = 3;
    localparam int unsigned RC_SW_BIT        = 4;
    localparam int unsigned RC_CMP_BIT       = 5;
    localparam int unsigned RC_CNV_BIT       = 6;

    localparam logic [7:0] WDOG_CMD_RELOAD   = 8'ha5;
    localparam logic [7:0] WDOG_CMD_DIS1     = 8'hde;
    localparam logic [7:0] WDOG_CMD_DIS2     = 8'had;
    localparam logic [7:0] WDOG_CMD_LOCK     = 8'hff;
    localparam int unsigned WDOG_STAT_BIT    = 4;
    localparam int unsigned WDOG_CFG_BIT     = 7;
    localparam logic [2:0] WDOG_INTV_RESET   = 3'h7;
    localparam int unsigned WDOG_CNT_W       = 21;

    // gray along reset -> run -> idle, stop adjacent to reset and idle, two bits from run
    typedef enum logic [1:0] {
        PMRC_RESET = 2'b00,
        PMRC_RUN   = 2'b01,
        PMRC_IDLE  = 2'b11,
        PMRC_STOP  = 2'b10
    } pmrc_mode_e;

    typedef struct packed {
        logic cnv;
        logic cmp;
        logic sw;
        logic wdog;
        logic clk_miss;
        logic por;
        logic pin;
    } pmrc_src_s;

endpackage

// >>> design/pmrc_top.sv
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
module pmrc_top
    import pmrc_pkg::*;
#(
    parameter int unsigned POR_CYC = POR_TIMEOUT_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rst_pin_in,
    output logic             rst_pin_out,
    output logic             rst_pin_oe,
    input  wire logic        supply_above_thresh,
    input  wire logic        supply_monitor_enable_pin,
    input  wire logic        convert_start_input,
    input  wire logic        comparator0_out,
    input  wire logic        clk_miss_timeout,
    input  wire logic        irq_pending,
    input  wire logic        osc_stable,
    output logic             core_rst_n,
    output logic             cpu_halt,
    output logic             cpu_run_en,
    output logic             osc_stop,
    output logic             osc_lowest_sel,
    output logic             periph_clk_en,
    output logic             port_latch_set
);

    localparam int unsigned POR_W = $clog2(POR_CYC + 1);

    // ---------------- reset release ----------------
    logic [1:0] rsync_ff;
    logic       rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsync_ff <= 2'b00;
        end else begin
            rsync_ff <= {rsync_ff[0], 1'b1};
        end
    end
    assign rst_sync_n = rsync_ff[1];

    // ---------------- pin synchronisers ----------------
    // a change counts only once stages two and three agree
    localparam int unsigned NSYNC = 6;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] filt_ff;
    assign raw_in = {clk_miss_timeout, comparator0_out, convert_start_input,
                     supply_monitor_enable_pin, supply_above_thresh, rst_pin_in};

    for (genvar g = 0; g < NSYNC; g++) begin : g_sync
        logic [2:0] s_ff;
        always_ff @(posedge clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                s_ff    <= 3'h7;
                filt_ff[g] <= 1'b1;
            end else begin
                s_ff    <= {s_ff[1:0], raw_in[g]};
                if (s_ff[1] == s_ff[2]) begin
                    filt_ff[g] <= s_ff[2];
                end
            end
        end
    end

    logic pin_low, supply_ok, mon_en, cnv_low, cmp_low, clk_miss_fire;
    assign pin_low   = ~filt_ff[0];
    assign supply_ok = filt_ff[1];
    assign mon_en    = filt_ff[2];
    assign cnv_low   = ~filt_ff[3];
    assign cmp_low   = ~filt_ff[4];
    assign clk_miss_fire = filt_ff[5];

    // ---------------- bus slave ----------------
    logic       ack_ff;
    logic       wr_acc;
    logic       rd_acc;
    logic [7:0] idx;
    logic [7:0] wbyte;

    assign idx             = avs_address[9:2];
    assign wbyte           = avs_writedata[7:0];
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign wr_acc          = avs_write & ack_ff & avs_byteenable[0];
    assign rd_acc          = avs_read & ack_ff;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
        end
    end

    // ---------------- state declarations ----------------
    pmrc_mode_e           mode_ff;
    pmrc_mode_e           nxt_mode;
    logic                 por_active_ff;
    logic [POR_W-1:0]     por_cnt_ff;
    logic [3:0]           hold_cnt_ff;
    logic                 in_rst_ff;
    pmrc_src_s            flags_ff;
    pmrc_src_s            cause_ff;
    pmrc_src_s            src;
    logic                 cnv_en_ff;
    logic                 cmp_en_ff;
    logic                 clk_miss_en_ff;
    logic                 sw_req_ff;
    logic                 wdog_en_ff;
    logic                 wdog_lock_ff;
    logic [2:0]           wdog_intv_ff;
    logic [WDOG_CNT_W-1:0] wdog_cnt_ff;
    logic [2:0]           dis_win_ff;
    logic                 wdog_fire;
    logic                 any_src;
    logic                 rst_now;

    // ---------------- power-on / supply monitor ----------------
    // power-fail restarts the same timeout as power-up
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            por_active_ff <= 1'b1;
            por_cnt_ff    <= '0;
        end else if (mon_en && !supply_ok) begin
            por_active_ff <= 1'b1;
            por_cnt_ff    <= '0;
        end else if (por_active_ff) begin
            if (!mon_en || por_cnt_ff == POR_W'(POR_CYC - 1)) begin
                por_active_ff <= 1'b0;
            end else begin
                por_cnt_ff <= por_cnt_ff + 1'b1;
            end
        end
    end

    // pin driven low only for monitor resets
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe  = por_active_ff;

    // ---------------- source merge ----------------
    assign src.pin = pin_low & ~por_active_ff;
    assign src.por = por_active_ff;
    assign src.clk_miss = clk_miss_en_ff & clk_miss_fire;
    assign src.wdog     = wdog_fire;
    assign src.sw  = sw_req_ff;
    assign src.cmp = cmp_en_ff & cmp_low;
    assign src.cnv = cnv_en_ff & cnv_low;
    assign any_src = |src;

    // reset asserts combinationally, leaves on a clock edge
    assign rst_now    = any_src | in_rst_ff;
    assign core_rst_n = ~rst_now;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            in_rst_ff   <= 1'b1;
            hold_cnt_ff <= 4'h0;
            cause_ff    <= '0;
        end else if (any_src) begin
            in_rst_ff   <= 1'b1;
            hold_cnt_ff <= 4'(PIN_HOLD_CYC - 1);
            // gather causes: the monitor's own pin drive echoes back late
            cause_ff    <= in_rst_ff ? pmrc_src_s'(cause_ff | src) : src;
        end else if (in_rst_ff) begin
            if (hold_cnt_ff == 4'h0) begin
                in_rst_ff <= 1'b0;
            end else begin
                hold_cnt_ff <= hold_cnt_ff - 1'b1;
            end
        end
    end

    // ---------------- cause flags ----------------
    // only rst_n resets them; each reset exit loads that reset's causes
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flags_ff <= '0;
        end else if (in_rst_ff && !any_src && hold_cnt_ff == 4'h0) begin
            flags_ff <= cause_ff;
            if (!cause_ff.por) begin
                flags_ff.por <= 1'b0;
            end
        end
    end

    // ---------------- mode machine ----------------
    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            PMRC_RESET: begin
                if (!rst_now && osc_stable) nxt_mode = PMRC_RUN;
            end
            PMRC_RUN: begin
                if (wr_acc && idx == PMC_IDX && wbyte[PMC_STOP_BIT]) begin
                    nxt_mode = PMRC_STOP;
                end else if (wr_acc && idx == PMC_IDX && wbyte[PMC_IDLE_BIT]) begin
                    nxt_mode = PMRC_IDLE;
                end
            end
            PMRC_IDLE: begin
                if (irq_pending) nxt_mode = PMRC_RUN;
            end
            PMRC_STOP: begin
                nxt_mode = PMRC_STOP;
            end
            default: nxt_mode = PMRC_RESET;
        endcase
        if (rst_now) nxt_mode = PMRC_RESET;
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_ff <= PMRC_RESET;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // no memory clear anywhere: data memory survives resets
    assign cpu_halt       = (mode_ff != PMRC_RUN);
    assign cpu_run_en     = (mode_ff == PMRC_RUN);
    assign osc_stop       = (mode_ff == PMRC_STOP);
    assign periph_clk_en  = (mode_ff != PMRC_STOP) && !rst_now;
    assign port_latch_set = rst_now;
    assign osc_lowest_sel = (mode_ff == PMRC_RESET);

    // ---------------- reset-cause enables ----------------
    // enables are ordinary registers, cleared by any reset
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cnv_en_ff <= 1'b0;
            cmp_en_ff <= 1'b0;
            clk_miss_en_ff <= 1'b0;
            sw_req_ff <= 1'b0;
        end else if (rst_now) begin
            cnv_en_ff <= 1'b0;
            cmp_en_ff <= 1'b0;
            clk_miss_en_ff <= 1'b0;
            sw_req_ff <= 1'b0;
        end else if (wr_acc && idx == RCAUSE_IDX) begin
            cnv_en_ff <= wbyte[RC_CNV_BIT];
            cmp_en_ff <= wbyte[RC_CMP_BIT];
            clk_miss_en_ff <= wbyte[RC_CLKMISS_BIT];
            sw_req_ff <= wbyte[RC_SW_BIT];
        end
    end

    // ---------------- watchdog ----------------
    logic [WDOG_CNT_W-1:0] wdog_limit;
    logic                  wdog_running;
    logic                  wdog_wr;
    assign wdog_limit   = WDOG_CNT_W'((1 << (6 + 2 * wdog_intv_ff)) - 1);
    assign wdog_running = wdog_en_ff && (mode_ff == PMRC_RUN || mode_ff == PMRC_IDLE);
    assign wdog_fire    = wdog_running && (wdog_cnt_ff == wdog_limit);
    assign wdog_wr      = wr_acc && idx == WDOG_IDX;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdog_en_ff   <= 1'b1;
            wdog_lock_ff <= 1'b0;
            wdog_intv_ff <= WDOG_INTV_RESET;
            wdog_cnt_ff  <= '0;
            dis_win_ff   <= 3'h0;
        end else if (rst_now) begin
            wdog_en_ff   <= 1'b1;
            wdog_lock_ff <= 1'b0;
            wdog_intv_ff <= WDOG_INTV_RESET;
            wdog_cnt_ff  <= '0;
            dis_win_ff   <= 3'h0;
        end else begin
            if (dis_win_ff != 3'h0) begin
                dis_win_ff <= dis_win_ff - 1'b1;
            end
            if (wdog_running) begin
                wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
            end
            if (wdog_wr) begin
                if (wbyte == WDOG_CMD_RELOAD) begin
                    wdog_en_ff  <= 1'b1;
                    wdog_cnt_ff <= '0;
                end else if (wbyte == WDOG_CMD_DIS1) begin
                    dis_win_ff <= 3'(WDOG_CMD_WIN_CYC);
                end else if (wbyte == WDOG_CMD_DIS2) begin
                    // second half late or locked: ignored
                    if (dis_win_ff != 3'h0 && !wdog_lock_ff) begin
                        wdog_en_ff <= 1'b0;
                    end
                end else if (wbyte == WDOG_CMD_LOCK) begin
                    wdog_lock_ff <= 1'b1;
                end else if (!wbyte[WDOG_CFG_BIT]) begin
                    wdog_intv_ff <= wbyte[2:0];
                end
            end
        end
    end

    // ---------------- read data ----------------
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            PMC_IDX:    rd_byte = PMC_RESET;
            RCAUSE_IDX: rd_byte = {1'b0, flags_ff};
            WDOG_IDX:   rd_byte = {3'h0, wdog_en_ff, 1'b0, wdog_intv_ff};
            default:    rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_ff) begin
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

    // ---------------- assertions ----------------
    property p_idle_entry;
        @(posedge clk) disable iff (!rst_sync_n)
        (mode_ff == PMRC_RUN && !rst_now && wr_acc && idx == PMC_IDX
         && wbyte[PMC_IDLE_BIT] && !wbyte[PMC_STOP_BIT]) |=> (mode_ff == PMRC_IDLE);
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

    property p_stop_entry;
        @(posedge clk) disable iff (!rst_sync_n)
        (mode_ff == PMRC_RUN && !rst_now && wr_acc && idx == PMC_IDX
         && wbyte[PMC_STOP_BIT]) |=> (mode_ff == PMRC_STOP && osc_stop && cpu_halt);
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");

    property p_idle_wake;
        @(posedge clk) disable iff (!rst_sync_n)
        (mode_ff == PMRC_IDLE && irq_pending && !rst_now) |=> cpu_run_en;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle not woken");

    property p_stop_hold;
        @(posedge clk) disable iff (!rst_sync_n)
        (mode_ff == PMRC_STOP && !rst_now) |=> (mode_ff == PMRC_STOP);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");

    property p_mode_reads_zero;
        @(posedge clk) disable iff (!rst_sync_n)
        (rd_acc && idx == PMC_IDX) |-> (avs_readdata[1:0] == 2'b00);
    endproperty
    a_mode_reads_zero: assert property (p_mode_reads_zero) else $error("mode bits read");

    property p_pin_hold;
        @(posedge clk) disable iff (!rst_sync_n)
        ($fell(any_src) && !por_active_ff) |-> (!core_rst_n)[*8] ##1 (!core_rst_n)[*4];
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("reset released early");

    property p_rst_immediate;
        @(posedge clk) disable iff (!rst_sync_n)
        any_src |-> (!core_rst_n && port_latch_set);
    endproperty
    a_rst_immediate: assert property (p_rst_immediate) else $error("reset late");

    property p_wdog_reset_state;
        @(posedge clk) disable iff (!rst_sync_n)
        $rose(core_rst_n) |-> (wdog_en_ff && wdog_intv_ff == WDOG_INTV_RESET);
    endproperty
    a_wdog_reset_state: assert property (p_wdog_reset_state) else $error("watchdog default");

    property p_wdog_idle;
        @(posedge clk) disable iff (!rst_sync_n)
        (mode_ff == PMRC_IDLE && wdog_en_ff && !rst_now && !wdog_wr)
        |=> (wdog_cnt_ff == $past(wdog_cnt_ff) + 1'b1) || !core_rst_n;
    endproperty
    a_wdog_idle: assert property (p_wdog_idle) else $error("watchdog stalled in idle");

    property p_por_pin;
        @(posedge clk) disable iff (!rst_sync_n)
        por_active_ff |-> (rst_pin_oe && !rst_pin_out && !core_rst_n);
    endproperty
    a_por_pin: assert property (p_por_pin) else $error("monitor not holding pin");

    property p_por_flag;
        @(posedge clk) disable iff (!rst_sync_n)
        ($rose(core_rst_n) && !cause_ff.por) |-> !flags_ff.por;
    endproperty
    a_por_flag: assert property (p_por_flag) else $error("power flag kept");

    property p_clk_miss_stop;
        @(posedge clk) disable iff (!rst_sync_n)
        (mode_ff == PMRC_STOP && clk_miss_en_ff && clk_miss_fire) |=> (mode_ff == PMRC_RESET);
    endproperty
    a_clk_miss_stop: assert property (p_clk_miss_stop) else $error("detector did not end stop");

endmodule // pmrc_top

// >>> tb/pmrc_ext.sv
`timescale 1ns/1ps
module pmrc_ext (
    input  wire logic press_n,
    input  wire logic supply_ok,
    input  wire logic mon_en,
    input  wire logic rst_pin_out,
    input  wire logic rst_pin_oe,
    output logic      rst_pin_in,
    output logic      supply_above_thresh,
    output logic      supply_monitor_enable_pin
);
    // pin has a board pull-up, so a released pin reads high, never the last level
    assign rst_pin_in                = press_n & ~(rst_pin_oe & ~rst_pin_out);
    assign supply_above_thresh       = supply_ok;
    assign supply_monitor_enable_pin = mon_en;
endmodule // pmrc_ext

// >>> tb/pmrc_top_tb.sv
`timescale 1ns/1ps
module pmrc_top_tb
    import pmrc_pkg::*;
;
    localparam int unsigned POR = 50;
    logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic        rst_pin_in, rst_pin_out, rst_pin_oe, supply_above_thresh;
    logic        supply_monitor_enable_pin, irq_pending, clk_miss_timeout;
    logic [1:0]  line_n;
    logic        core_rst_n, cpu_halt, cpu_run_en, osc_stop, osc_lowest_sel;
    logic        periph_clk_en, port_latch_set, press_n, supply_ok;
    int          num_errors = 0;
    int          num_checks = 0;

    pmrc_top #(.POR_CYC(POR)) i_dut (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .supply_above_thresh(supply_above_thresh),
        .supply_monitor_enable_pin(supply_monitor_enable_pin),
        .convert_start_input(line_n[1]), .comparator0_out(line_n[0]),
        .clk_miss_timeout(clk_miss_timeout),
        .irq_pending(irq_pending), .osc_stable(1'b1), .core_rst_n(core_rst_n),
        .cpu_halt(cpu_halt), .cpu_run_en(cpu_run_en), .osc_stop(osc_stop),
        .osc_lowest_sel(osc_lowest_sel), .periph_clk_en(periph_clk_en),
        .port_latch_set(port_latch_set));

    pmrc_ext i_ext (
        .press_n(press_n), .supply_ok(supply_ok), .mon_en(1'b1),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .rst_pin_in(rst_pin_in),
        .supply_above_thresh(supply_above_thresh),
        .supply_monitor_enable_pin(supply_monitor_enable_pin));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus(input logic wr, input logic [3:0] be, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        avs_address    <= {idx, 2'b00};
        avs_writedata  <= {24'h0, wd};
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) num_errors++;
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        // one idle edge keeps back-to-back calls from driving a strobe twice
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(1'b1, 4'h1, idx, wd, d);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] mask,
                          input logic [7:0] exp);
        logic [7:0] d;
        bus(1'b0, 4'h1, idx, 8'h00, d);
        chk(what, exp, d & mask);
    endtask

    task automatic wait_lvl(input logic lvl, input int lim, output int n);
        n = 0;
        while (core_rst_n !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic t_power_up();
        int n;
        cyc(20);
        rst_n <= 1'b1;
        cyc(10);
        chk("pin_drive", 8'h01, rst_pin_oe & ~rst_pin_in);
        chk("latch_set", 8'h01, port_latch_set & cpu_halt);
        chk("slow_osc", 8'h01, osc_lowest_sel);
        wait_lvl(1'b1, 300, n);
        chk("por_len", 8'h01, (n + 10) >= (POR + PIN_HOLD_CYC));
        cyc(2);
        chk("run", 8'h01, cpu_run_en);
        rd_chk("por_flag", RCAUSE_IDX, 8'h02, 8'h02);
        rd_chk("wdog_on", WDOG_IDX, 8'h17, 8'h17);
    endtask

    task automatic t_idle();
        wr(PMC_IDX, 8'h01);
        cyc(2);
        chk("idle_halt", 8'h01, cpu_halt & ~cpu_run_en);
        chk("idle_clk", 8'h01, periph_clk_en & ~osc_stop & core_rst_n);
        rd_chk("pmc_read", PMC_IDX, 8'hff, 8'h00);
        irq_pending <= 1'b1;
        cyc(1);
        irq_pending <= 1'b0;
        cyc(1);
        chk("wake", 8'h01, cpu_run_en);
        wr(PMC_IDX, 8'h00);
        cyc(2);
        chk("zero_write", 8'h01, cpu_run_en);
        rd_chk("unmapped", 8'h10, 8'hff, 8'h00);
    endtask

    task automatic t_stop_pin();
        int n;
        wr(PMC_IDX, 8'h02);
        cyc(2);
        chk("stop", 8'h01, osc_stop & cpu_halt & ~periph_clk_en);
        irq_pending <= 1'b1;
        cyc(5);
        chk("stop_irq", 8'h01, osc_stop);
        irq_pending <= 1'b0;
        press_n     <= 1'b0;
        wait_lvl(1'b0, 10, n);
        cyc(3);
        chk("pin_rst", 8'h01, port_latch_set & ~core_rst_n);
        press_n <= 1'b1;
        wait_lvl(1'b1, 100, n);
        chk("pin_hold", 8'h01, n >= PIN_HOLD_CYC);
        cyc(2);
        rd_chk("pin_flag", RCAUSE_IDX, 8'h7f, 8'h01);
    endtask

    task automatic t_soft();
        int n;
        logic [7:0] d;
        bus(1'b1, 4'h0, RCAUSE_IDX, 8'h10, d);
        cyc(3);
        chk("be_ignored", 8'h01, core_rst_n);
        wr(RCAUSE_IDX, 8'h10);
        chk("sw_rst", 8'h00, core_rst_n);
        wait_lvl(1'b1, 100, n);
        cyc(2);
        rd_chk("sw_flag", RCAUSE_IDX, 8'h7f, 8'h10);
    endtask

    task automatic t_wdog();
        int n;
        wr(WDOG_IDX, 8'h00);
        wr(WDOG_IDX, 8'ha5);
        wr(PMC_IDX, 8'h01);
        wait_lvl(1'b0, 200, n);
        chk("wdog_fire", 8'h01, n > 50 && n < 70);
        wait_lvl(1'b1, 100, n);
        cyc(2);
        rd_chk("wdog_flag", RCAUSE_IDX, 8'h7f, 8'h08);
        rd_chk("wdog_back", WDOG_IDX, 8'h17, 8'h17);
    endtask

    task automatic t_clk_miss();
        int n;
        wr(RCAUSE_IDX, 8'h04);
        wr(PMC_IDX, 8'h02);
        clk_miss_timeout <= 1'b1;
        wait_lvl(1'b0, 10, n);
        clk_miss_timeout <= 1'b0;
        chk("clk_miss_rst", 8'h01, n < 10);
        wait_lvl(1'b1, 100, n);
        cyc(2);
        rd_chk("clk_miss_flag", RCAUSE_IDX, 8'h7f, 8'h04);
    endtask

    // en bit6 pulls the convert line low, bit5 the comparator line
    task automatic t_line(input logic [7:0] en);
        int n;
        wr(RCAUSE_IDX, en);
        line_n <= ~en[6:5];
        wait_lvl(1'b0, 10, n);
        line_n <= 2'b11;
        chk("line_rst", 8'h01, n < 10);
        wait_lvl(1'b1, 100, n);
        cyc(2);
        rd_chk("line_flag", RCAUSE_IDX, 8'h7f, en);
    endtask

    task automatic t_power_fail();
        int n;
        supply_ok <= 1'b0;
        cyc(7);
        chk("pf_drive", 8'h01, rst_pin_oe & ~core_rst_n);
        supply_ok <= 1'b1;
        wait_lvl(1'b1, 300, n);
        chk("pf_len", 8'h01, n >= POR);
        cyc(2);
        rd_chk("pf_flag", RCAUSE_IDX, 8'h02, 8'h02);
    endtask

    initial begin
        rst_n          = 1'b0;
        avs_address    = '0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = '0;
        avs_byteenable = 4'h1;
        irq_pending    = 1'b0;
        clk_miss_timeout = 1'b0;
        line_n         = 2'b11;
        press_n        = 1'b1;
        supply_ok      = 1'b1;
        @(posedge clk);
        t_power_up();
        t_idle();
        t_stop_pin();
        t_soft();
        t_wdog();
        t_clk_miss();
        t_line(8'h40);
        t_line(8'h20);
        t_power_fail();
        summarize();
    end

    // whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end
endmodule // pmrc_top_tb
